/* File: rtl/dic_channel.v */
`timescale 1ns/100ps
`include "dic_map.vh"
// ==========================================
// One input channel: delay qualifier and rising-edge counter
module dic_channel (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Timing
  input wire ms_tick_i,
  // Settings
  input wire ac_mode_i,
  input wire [`DIC_DELAY_W-1:0] pickup_i,
  input wire [`DIC_DELAY_W-1:0] release_i,
  input wire clear_i,
  // Level after polarity, sampled each program cycle
  input wire level_i,
  // Results
  output reg state_o,
  output reg [`DIC_CNT_W-1:0] count_o
);
  reg [`DIC_TIMER_W-1:0] timer;
  reg [`DIC_TIMER_W-1:0] need;
  // Fixed extra release time in alternating mode, cut to timer width below
  localparam [31:0] AC_EXTRA = `DIC_AC_DELAY_MS;

  // Delay that the pending change must hold for
  always @* begin
    if (level_i) begin
      need = {1'b0, pickup_i};
    end else begin
      need = {1'b0, release_i} + (ac_mode_i ? AC_EXTRA[`DIC_TIMER_W-1:0] : {`DIC_TIMER_W{1'b0}});
    end
  end

  // Timer restarts whenever the level agrees with the state again
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer <= {`DIC_TIMER_W{1'b0}};
      state_o <= 1'b0;
    end else if (level_i == state_o) begin
      timer <= {`DIC_TIMER_W{1'b0}};
    end else if (timer >= need) begin
      state_o <= level_i;
      timer <= {`DIC_TIMER_W{1'b0}};
    end else if (ms_tick_i) begin
      timer <= timer + 1'b1;
    end
  end

  // Count 0 to 1 changes; a change in the clear cycle still counts
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= {`DIC_CNT_W{1'b0}};
    end else begin
      if (level_i != state_o && timer >= need && level_i) begin
        count_o <= (clear_i ? {`DIC_CNT_W{1'b0}} : count_o) + 1'b1;
      end else if (clear_i) begin
        count_o <= {`DIC_CNT_W{1'b0}};
      end
    end
  end
endmodule

/* File: rtl/dic_map.vh */
`ifndef DIC_MAP_VH
`define DIC_MAP_VH
// ==========================================
// Register byte offsets
`define DIC_ADR_POLARITY 8'h00
`define DIC_ADR_AC_MODE 8'h04
`define DIC_ADR_RAW 8'h08
`define DIC_ADR_STATE 8'h0C
`define DIC_ADR_RELAY_MAP 8'h10
`define DIC_ADR_CNT_CLEAR 8'h14
`define DIC_ADR_PICKUP_BASE 8'h20
`define DIC_ADR_RELEASE_BASE 8'h40
`define DIC_ADR_COUNT_BASE 8'h60
`define DIC_BANK_MASK 8'hE0
// ==========================================
// Reset values
`define DIC_RST_POLARITY 8'h00
`define DIC_RST_AC_MODE 8'h00
`define DIC_RST_RELAY_MAP 8'h00
`define DIC_RST_DELAY 21'h000000
// ==========================================
// Field values
`define DIC_POL_NO 1'b0
`define DIC_POL_NC 1'b1
`define DIC_CLEAR_CMD 1'b1
// ==========================================
// Timing
`define DIC_CLK_HZ 20000000
`define DIC_TICK_US 1000
`define DIC_MS_CYCLES ((`DIC_CLK_HZ / 1000000) * `DIC_TICK_US)
`define DIC_CYCLE_MS 5
`define DIC_AC_DELAY_MS 30
`define DIC_DELAY_MAX_MS 1800000
`define DIC_DELAY_W 21
`define DIC_TIMER_W 22
`define DIC_CNT_W 32
`endif

/* File: rtl/dic_tick.v */
`timescale 1ns/100ps
`include "dic_map.vh"
// ==========================================
// Millisecond tick and program cycle tick
module dic_tick #(
  parameter MS_CYCLES = `DIC_MS_CYCLES,
  parameter CYCLE_MS = `DIC_CYCLE_MS
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Tick pulses
  output reg ms_tick_o,
  output reg cycle_tick_o
);
  reg [31:0] div;
  reg [7:0] ms_cnt;

  // Prescaler and program cycle counter
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 32'h00000000;
      ms_cnt <= 8'h00;
      ms_tick_o <= 1'b0;
      cycle_tick_o <= 1'b0;
    end else begin
      ms_tick_o <= 1'b0;
      cycle_tick_o <= 1'b0;
      if (div == MS_CYCLES - 1) begin
        div <= 32'h00000000;
        ms_tick_o <= 1'b1;
        if (ms_cnt == CYCLE_MS - 1) begin
          ms_cnt <= 8'h00;
          cycle_tick_o <= 1'b1;
        end else begin
          ms_cnt <= ms_cnt + 8'h01;
        end
      end else begin
        div <= div + 32'h00000001;
      end
    end
  end
endmodule

/* File: rtl/dic_top.v */
// What this block does
// - Sample every input channel once per 5 ms program cycle.
// - Polarity 0 reports energized as 1; polarity 1 reports energized as 0.
// - Qualify each 0 to 1 change with a programmable pickup delay, default zero.
// - Qualify each 1 to 0 change with a separate release delay, default zero.
// - Alternating input mode adds a fixed 30 ms to the release delay.
// - Internal consumers see the state one program cycle later.
// - Directly mapped relay outputs update one further program cycle later.
// - Each channel counts its 0 to 1 state changes in 32 bits.
// - Writing the clear command restarts that channel's counter from zero, still counting a 0 to 1 change in the same cycle.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`include "dic_map.vh"
module dic_top #(
  parameter N = 8,
  parameter MS_CYCLES = `DIC_MS_CYCLES
) (
  // Clock and reset
  input wire CLK_I,
  input wire SYS_RST_I,
  // Wishbone slave
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  // Field contacts, high when energized
  input wire [N-1:0] DIN_I,
  // Conditioned state for internal logic
  output reg [N-1:0] STATE_O,
  // Relay drive for directly mapped channels
  output reg [N-1:0] RELAY_OUTPUT_O
);
  localparam DW = `DIC_DELAY_W;
  localparam CW = `DIC_CNT_W;

  // ==========================================
  // Byte lane merge, shared by all writable registers except the clear strobes
  function [31:0] dic_merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    integer b;
    begin
      dic_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          dic_merge[b*8 +: 8] = dat[b*8 +: 8];
        end
      end
    end
  endfunction

  // Delays above the range are held at the top of the range
  function [DW-1:0] dic_clamp;
    input [31:0] v;
    reg [31:0] top;
    begin
      top = `DIC_DELAY_MAX_MS;
      if (v > top) begin
        dic_clamp = top[DW-1:0];
      end else begin
        dic_clamp = v[DW-1:0];
      end
    end
  endfunction

  // Word aligned hit in one per-channel bank, channel within range
  function dic_bank_hit;
    input [7:0] adr;
    input [7:0] base;
    begin
      dic_bank_hit = ((adr & `DIC_BANK_MASK) == base) && (adr[1:0] == 2'b00) && ({29'h00000000, adr[4:2]} < N);
    end
  endfunction

  // ==========================================
  // Ticks
  wire ms_tick;
  wire cycle_tick;

  dic_tick #(
    .MS_CYCLES(MS_CYCLES),
    .CYCLE_MS(`DIC_CYCLE_MS)
  ) u_tick (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .ms_tick_o(ms_tick),
    .cycle_tick_o(cycle_tick)
  );

  // ==========================================
  // Bus decode
  reg [N-1:0] polarity;
  reg [N-1:0] alternating_input_mode;
  reg [N-1:0] relay_map;
  reg [N-1:0] raw;
  reg [N-1:0] clear;
  reg [N*DW-1:0] pickup_all;
  reg [N*DW-1:0] release_all;
  wire [N*CW-1:0] count_all;
  wire [N-1:0] cond_state;
  wire req = CYC_I & STB_I & ~ACK_O;
  wire wr = req & WE_I;
  wire [2:0] ch = ADR_I[4:2];
  // Bank hits; pickup and release feed the write, merge and read paths, count only the read path
  wire hit_pickup = dic_bank_hit(ADR_I, `DIC_ADR_PICKUP_BASE);
  wire hit_release = dic_bank_hit(ADR_I, `DIC_ADR_RELEASE_BASE);
  wire hit_count = dic_bank_hit(ADR_I, `DIC_ADR_COUNT_BASE);
  // Working values of the combinational paths
  reg [31:0] next_dat;
  reg [31:0] merged;
  reg [N-1:0] level;
  integer i;
  integer j;

  // ==========================================
  // Register writes; unmapped writes are acknowledged and dropped
  // Writes land at the edge that takes the request, the same edge that raises ack
  // Polarity, one bit per channel
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      polarity <= `DIC_RST_POLARITY;
    end else if (wr && (ADR_I == `DIC_ADR_POLARITY)) begin
      polarity <= merged[N-1:0];
    end
  end

  // Alternating input mode, one bit per channel
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      alternating_input_mode <= `DIC_RST_AC_MODE;
    end else if (wr && (ADR_I == `DIC_ADR_AC_MODE)) begin
      alternating_input_mode <= merged[N-1:0];
    end
  end

  // Relay map; unmapped channels never drive their relay
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      relay_map <= `DIC_RST_RELAY_MAP;
    end else if (wr && (ADR_I == `DIC_ADR_RELAY_MAP)) begin
      relay_map <= merged[N-1:0];
    end
  end

  // Clear strobes last one cycle; a strobe held past ack clears again once ack falls
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      clear <= {N{1'b0}};
    end else begin
      for (i = 0; i < N; i = i + 1) begin
        clear[i] <= wr && (ADR_I == `DIC_ADR_CNT_CLEAR) && SEL_I[i/8] && (DAT_I[i] == `DIC_CLEAR_CMD);
      end
    end
  end

  // Pickup delays, clamped to the top of the range on the way in
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pickup_all <= {N{`DIC_RST_DELAY}};
    end else if (wr && hit_pickup) begin
      pickup_all[ch*DW +: DW] <= dic_clamp(merged);
    end
  end

  // Release delays, clamped the same way
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      release_all <= {N{`DIC_RST_DELAY}};
    end else if (wr && hit_release) begin
      release_all[ch*DW +: DW] <= dic_clamp(merged);
    end
  end

  // Old value of the addressed writable register, for byte lane merge
  always @* begin
    merged = 32'h00000000;
    case (ADR_I)
      `DIC_ADR_POLARITY: merged[N-1:0] = polarity;
      `DIC_ADR_AC_MODE: merged[N-1:0] = alternating_input_mode;
      `DIC_ADR_RELAY_MAP: merged[N-1:0] = relay_map;
      default: begin
        if (hit_pickup) begin
          merged[DW-1:0] = pickup_all[ch*DW +: DW];
        end
        if (hit_release) begin
          merged[DW-1:0] = release_all[ch*DW +: DW];
        end
      end
    endcase
    merged = dic_merge(merged, DAT_I, SEL_I);
  end

  // ==========================================
  // Read mux; unmapped addresses read as zero
  always @* begin
    next_dat = 32'h00000000;
    case (ADR_I)
      `DIC_ADR_POLARITY: next_dat[N-1:0] = polarity;
      `DIC_ADR_AC_MODE: next_dat[N-1:0] = alternating_input_mode;
      `DIC_ADR_RAW: next_dat[N-1:0] = raw;
      `DIC_ADR_STATE: next_dat[N-1:0] = cond_state;
      `DIC_ADR_RELAY_MAP: next_dat[N-1:0] = relay_map;
      default: begin
        if (hit_pickup) begin
          next_dat[DW-1:0] = pickup_all[ch*DW +: DW];
        end
        if (hit_release) begin
          next_dat[DW-1:0] = release_all[ch*DW +: DW];
        end
        if (hit_count) begin
          next_dat = count_all[ch*CW +: CW];
        end
      end
    endcase
  end

  // One wait state: ack a cycle after the strobe, drop it the next
  // A strobe still held after ack is taken again only once ack falls
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= req;
    end
  end

  // Read data stands until the next read, so a slow master still sees it
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DAT_O <= 32'h00000000;
    end else if (req && !WE_I) begin
      DAT_O <= next_dat;
    end
  end

  // ==========================================
  // Sampling and staged outputs
  // Worst case chain: 5 ms to sample, 5 to stage, 5 more to the relay
  // Reported level: energized reads 1 unless the channel is normally closed
  always @* begin
    level = {N{1'b0}};
    for (j = 0; j < N; j = j + 1) begin
      level[j] = raw[j] ^ (polarity[j] == `DIC_POL_NC);
    end
  end

  // Held between cycle ticks, so contact bounce between two cycle ticks is never seen
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      raw <= {N{1'b0}};
    end else if (cycle_tick) begin
      raw <= DIN_I;
    end
  end

  // Internal consumers act on the qualified state one cycle later
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      STATE_O <= {N{1'b0}};
    end else if (cycle_tick) begin
      STATE_O <= cond_state;
    end
  end

  // Relay drive follows the staged state, one further cycle behind
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RELAY_OUTPUT_O <= {N{1'b0}};
    end else if (cycle_tick) begin
      RELAY_OUTPUT_O <= STATE_O & relay_map;
    end
  end

  // ==========================================
  // Channels
  // Each channel owns its qualifier timer and its edge counter
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_ch
      dic_channel u_ch (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .ms_tick_i(ms_tick),
        .ac_mode_i(alternating_input_mode[g]),
        .pickup_i(pickup_all[g*DW +: DW]),
        .release_i(release_all[g*DW +: DW]),
        .clear_i(clear[g]),
        .level_i(level[g]),
        .state_o(cond_state[g]),
        .count_o(count_all[g*CW +: CW])
      );
    end
  endgenerate
endmodule

/* File: tb/dic_field.sv */
`timescale 1ns/100ps
// ==========================================
// Field contacts; alternating ones dip at zero crossings
module dic_field #(
  parameter MS_CYCLES = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Contact commands
  input wire [7:0] energize_i,
  input wire [7:0] alternating_i,
  // Terminal levels
  output wire [7:0] din_o
);
  // 7 ms wave, off-beat with the 5 ms scan so dips do land on samples
  reg [31:0] ph;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph <= 32'h00000000;
    end else begin
      ph <= (ph == 7 * MS_CYCLES - 1) ? 32'h00000000 : ph + 32'h00000001;
    end
  end
  // Two dead milliseconds each period on alternating contacts
  assign din_o = energize_i & ~(alternating_i & {8{ph < 2 * MS_CYCLES}});
endmodule

/* File: tb/dic_top_asserts.sv */
`timescale 1ns/100ps
// ==========================================
// Port checker for the input conditioner
module dic_top_asserts #(
  parameter N = 8,
  parameter MS_CYCLES = 20000
) (
  // Watched ports
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:0] ADR_I,
  input wire [31:0] DAT_O,
  input wire ACK_O,
  input wire [N-1:0] STATE_O,
  input wire [N-1:0] RELAY_OUTPUT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Cycles since the state moved; saturates so a long quiet spell never wraps
  reg [31:0] gap;
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      gap <= 32'h00FFFFFF;
    end else if ($changed(STATE_O)) begin
      gap <= 32'h00000000;
    end else if (gap != 32'h00FFFFFF) begin
      gap <= gap + 32'h00000001;
    end
  end
  // Bus answer timing and data
  property p_ack_next; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; ACK_O |-> $past(CYC_I && STB_I); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hold; $changed(DAT_O) |-> ACK_O && $past(!WE_I); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_unmapped; ACK_O && $past(!WE_I && (ADR_I[7] || ADR_I == 8'h14)) |-> DAT_O == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("empty place read nonzero");
  // State and relay cadence
  property p_state_gap; $changed(STATE_O) |-> gap >= 5 * MS_CYCLES - 1; endproperty
  a_state_gap: assert property (p_state_gap) else $error("state moved off scan tick");
  property p_relay_sub; $changed(RELAY_OUTPUT_O) |-> (RELAY_OUTPUT_O & ~$past(STATE_O)) == {N{1'b0}}; endproperty
  a_relay_sub: assert property (p_relay_sub) else $error("relay ahead of state");
  property p_rst_clear; $fell(SYS_RST_I) |-> STATE_O == {N{1'b0}} && RELAY_OUTPUT_O == {N{1'b0}}; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs set after reset");
  // Main scenarios reached
  c_pick: cover property ($rose(STATE_O[0]));
  c_relay: cover property ($rose(RELAY_OUTPUT_O[0]));
  c_read: cover property (ACK_O && $past(!WE_I));
endmodule
bind dic_top dic_top_asserts #(.N(N), .MS_CYCLES(MS_CYCLES)) u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .STATE_O(STATE_O),
  .RELAY_OUTPUT_O(RELAY_OUTPUT_O));

/* File: tb/dic_top_tb.sv */
`timescale 1ns/100ps
// ==========================================
// Bench for the input conditioner
module dic_top_tb;
  localparam MS = 4;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg [7:0] adr = 8'h00, energ = 8'h00, alt = 8'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] wdat = 32'h00000000, rdat;
  wire [31:0] dat_o;
  wire ack;
  wire [7:0] din, state, relay;
  integer error_cnt = 0;
  integer n_compared = 0;
  dic_top #(.N(8), .MS_CYCLES(MS)) u_dut (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .DIN_I(din), .STATE_O(state),
    .RELAY_OUTPUT_O(relay));
  dic_field #(.MS_CYCLES(MS)) u_field (.clk_i(clk), .rst_i(rst), .energize_i(energ), .alternating_i(alt),
    .din_o(din));
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================
  // Shared helpers
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task ms(input integer n);
    repeat (n * MS) @(posedge clk);
  endtask
  // One classic cycle; only the watchdog ends a wait for ack
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= d;
      do begin
        @(posedge clk);
      end while (ack !== 1'b1);
      chk({31'h00000000, ack}, 32'h00000001);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      wb(1'b0, a, 32'h00000000);
      chk(rdat, e);
    end
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    begin
      rd(8'h00, 32'h00000000);
      rd(8'h04, 32'h00000000);
      rd(8'h5C, 32'h00000000);
      rd(8'h60, 32'h00000000);
      wb(1'b1, 8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'h001B7740);
      wb(1'b1, 8'h0C, 32'h000000FF);
      rd(8'h0C, 32'h00000000);
      wb(1'b1, 8'h80, 32'hFFFFFFFF);
      rd(8'h80, 32'h00000000);
    end
  endtask
  // Channel 0 qualified, channel 1 pulse too short to count
  task t_pickup;
    begin
      wb(1'b1, 8'h20, 32'h0000000A);
      wb(1'b1, 8'h24, 32'h0000000A);
      wb(1'b1, 8'h10, 32'h00000001);
      @(posedge clk);
      energ <= 8'h03;
      ms(4);
      energ <= 8'h01;
      ms(5);
      chk(state, 8'h00);
      ms(13);
      chk(state, 8'h01);
      ms(5);
      chk(relay, 8'h01);
      rd(8'h60, 32'h00000001);
      rd(8'h64, 32'h00000000);
      rd(8'h10, 32'h00000001);
      rd(8'h0C, 32'h00000001);
    end
  endtask
  task t_release;
    begin
      wb(1'b1, 8'h40, 32'h0000000A);
      @(posedge clk);
      energ <= 8'h00;
      ms(9);
      chk(state, 8'h01);
      ms(13);
      chk(state, 8'h00);
    end
  endtask
  // Alternating contact on channel 3 must hold through its dips
  task t_ac;
    begin
      wb(1'b1, 8'h04, 32'h00000008);
      @(posedge clk);
      alt <= 8'h08;
      energ <= 8'h08;
      ms(17);
      repeat (40) begin
        ms(1);
        chk(state, 8'h08);
      end
      energ <= 8'h00;
      ms(25);
      chk(state, 8'h08);
      ms(20);
      chk(state, 8'h00);
    end
  endtask
  task t_pol;
    begin
      wb(1'b1, 8'h00, 32'h00000004);
      ms(12);
      chk(state, 8'h04);
      @(posedge clk);
      energ <= 8'h04;
      ms(12);
      chk(state, 8'h00);
      rd(8'h68, 32'h00000001);
      rd(8'h08, 32'h00000004);
      wb(1'b1, 8'h14, 32'h00000004);
      rd(8'h68, 32'h00000000);
      rd(8'h60, 32'h00000001);
      rd(8'h14, 32'h00000000);
    end
  endtask
  task summarize;
    begin
      $display("compared=%0d errors=%0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_pickup;
    t_release;
    t_ac;
    t_pol;
    summarize;
  end
  // Watchdog, well past the roughly 800 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt = error_cnt + 1;
    summarize;
  end
endmodule
